// ---- design/afc_pkg.sv ----
// Operation
// R1: Writing one to transfer bit applies staged settings.
// R2: Staged writes change nothing until transfer.
// R3: Transfer bit clears itself after applying.
// R4: Local writes go to every enabled channel.
// R5: Global bit five picks power-down pin action.
// R6: Channel power mode resets to normal operation.
// R7: Clock divide ratio is code plus one.
// R8: Divider phase delays by code input cycles.
// R9: Shuffle bit enables shuffle, resets enabled.
// R10: Test field selects one of eight patterns.
// R11: Selected pattern replaces conversion data on outputs.
// R12: Pseudo-noise generators held reset while bit zero.
// R13: Self-test enable bit starts channel self-test.
// R14: Self-test reset bit zero holds logic reset.
// R15: Offset trim is signed LSB count, resets zero.
// R16: Open bits ignore writes and read zero.
package afc_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] ADDR_CHAN_INDEX = 8'h05;
  localparam logic [7:0] ADDR_POWER_MODE = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_DIV = 8'h0B;
  localparam logic [7:0] ADDR_SHUFFLE = 8'h0C;
  localparam logic [7:0] ADDR_TEST_PATTERN = 8'h0D;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h0E;
  localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] ADDR_APPLY = 8'hFF;

  // Writable bit masks; every bit outside a mask is open.
  localparam logic [7:0] MASK_POWER_MODE = 8'h23;
  localparam logic [7:0] MASK_CLOCK_DIV = 8'h3F;
  localparam logic [7:0] MASK_SHUFFLE = 8'h01;
  localparam logic [7:0] MASK_TEST_PATTERN = 8'h37;
  localparam logic [7:0] MASK_SELF_TEST = 8'h05;
  localparam logic [7:0] MASK_OFFSET_TRIM = 8'hFF;

  // Field positions.
  localparam int PD_PIN_FUNC_BIT = 5;
  localparam int APPLY_BIT = 0;
  localparam int SHUFFLE_BIT = 0;
  localparam int LONG_PN_RUN_BIT = 5;
  localparam int SHORT_PN_RUN_BIT = 4;
  localparam int SELF_TEST_EN_BIT = 0;
  localparam int SELF_TEST_RUN_BIT = 2;

  // Reset values.
  localparam logic [7:0] RST_POWER_MODE = 8'h00;
  localparam logic [7:0] RST_CLOCK_DIV = 8'h00;
  localparam logic [7:0] RST_SHUFFLE = 8'h01;
  localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
  localparam logic [7:0] RST_SELF_TEST = 8'h00;
  localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;

  localparam int NUM_CHAN = 4;

  // Power mode codes of the per-channel field.
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_DOWN = 2'h1;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  // Host access to the register file.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afc_req_t;

  // Active settings for one channel.
  typedef struct packed {
    logic [1:0] power_mode;
    logic shuffle_en;
    logic [2:0] test_sel;
    logic long_pn_run;
    logic short_pn_run;
    logic self_test_start;
    logic self_test_run;
    logic signed [7:0] offset_trim;
  } afc_chan_t;

  // Active global settings.
  typedef struct packed {
    logic pd_pin_standby;
    logic [2:0] clk_div_ratio_m1;
    logic [2:0] clk_div_phase;
  } afc_glob_t;

endpackage

// ---- design/afc_regs.sv ----
`timescale 1ns/100ps
module afc_regs
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input afc_pkg::afc_req_t req_i,
  input wire logic [afc_pkg::NUM_CHAN-1:0] chan_en_i,
  output logic [7:0] rdata_o,
  output afc_pkg::afc_glob_t glob_o,
  output afc_pkg::afc_chan_t [afc_pkg::NUM_CHAN-1:0] chan_o
);
  import afc_pkg::*;

  // ********************************************************************
  // Storage
  // ********************************************************************
  // Staged copies, written by the host; they steer nothing directly.
  logic [7:0] stg_power_glob;
  logic [7:0] stg_clock_div;
  logic [7:0] stg_local [NUM_CHAN][5];
  // Active copies, loaded only by a transfer.
  logic [7:0] act_power_glob;
  logic [7:0] act_clock_div;
  logic [7:0] act_local [NUM_CHAN][5];
  // Transfer bit; set by the host, cleared by the block.
  logic apply_bit;
  logic [7:0] rdata;

  logic [7:0] next_stg_power_glob;
  logic [7:0] next_stg_clock_div;
  logic [7:0] next_stg_local [NUM_CHAN][5];
  logic [7:0] next_act_power_glob;
  logic [7:0] next_act_clock_div;
  logic [7:0] next_act_local [NUM_CHAN][5];
  logic next_apply_bit;
  logic [7:0] next_rdata;

  // Maps a local address to its slot; slot 5 means not local.
  function automatic logic [2:0] local_slot(input logic [7:0] a);
    case (a)
      ADDR_POWER_MODE: local_slot = 3'h0;
      ADDR_SHUFFLE: local_slot = 3'h1;
      ADDR_TEST_PATTERN: local_slot = 3'h2;
      ADDR_SELF_TEST: local_slot = 3'h3;
      ADDR_OFFSET_TRIM: local_slot = 3'h4;
      default: local_slot = 3'h5;
    endcase
  endfunction

  // Writable mask for each local slot.
  function automatic logic [7:0] slot_mask(input logic [2:0] s);
    case (s)
      3'h0: slot_mask = MASK_POWER_MODE & ~(8'h01 << PD_PIN_FUNC_BIT);
      3'h1: slot_mask = MASK_SHUFFLE;
      3'h2: slot_mask = MASK_TEST_PATTERN;
      3'h3: slot_mask = MASK_SELF_TEST;
      3'h4: slot_mask = MASK_OFFSET_TRIM;
      default: slot_mask = 8'h00;
    endcase
  endfunction

  // Reset value for each local slot.
  function automatic logic [7:0] slot_reset(input logic [2:0] s);
    case (s)
      3'h0: slot_reset = RST_POWER_MODE;
      3'h1: slot_reset = RST_SHUFFLE;
      3'h2: slot_reset = RST_TEST_PATTERN;
      3'h3: slot_reset = RST_SELF_TEST;
      3'h4: slot_reset = RST_OFFSET_TRIM;
      default: slot_reset = 8'h00;
    endcase
  endfunction

  // The lowest-numbered enabled channel is read when several channels are selected.
  function automatic int read_chan(input logic [NUM_CHAN-1:0] en);
    read_chan = 0;
    for (int c = NUM_CHAN - 1; c >= 0; c--)
    begin
      if (en[c])
      begin
        read_chan = c;
      end
    end
  endfunction

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  // Host writes land in the staged set; a transfer copies all at once.
  always_comb
  begin
    logic [2:0] slot;
    int rc;
    slot = local_slot(req_i.addr);
    rc = read_chan(chan_en_i);
    next_stg_power_glob = stg_power_glob;
    next_stg_clock_div = stg_clock_div;
    next_stg_local = stg_local;
    next_act_power_glob = act_power_glob;
    next_act_clock_div = act_clock_div;
    next_act_local = act_local;
    next_rdata = rdata;
    // A set transfer bit is consumed this cycle and clears itself.
    next_apply_bit = 1'b0; // see R3
    if (apply_bit)
    begin
      // Everything moves together so no half-updated mix is ever seen.
      next_act_power_glob = stg_power_glob; // see R1
      next_act_clock_div = stg_clock_div; // see R1
      next_act_local = stg_local; // see R1
    end
    if (req_i.wr)
    begin
      if (req_i.addr == ADDR_APPLY)
      begin
        next_apply_bit = req_i.wdata[APPLY_BIT]; // see R1
      end
      else if (req_i.addr == ADDR_CLOCK_DIV)
      begin
        next_stg_clock_div = req_i.wdata & MASK_CLOCK_DIV; // see R2, R16
      end
      if (req_i.addr == ADDR_POWER_MODE)
      begin
        // The pin function bit is global and ignores the channel index.
        next_stg_power_glob = req_i.wdata & (8'h01 << PD_PIN_FUNC_BIT); // see R5, R16
      end
      if (slot != 3'h5)
      begin
        for (int c = 0; c < NUM_CHAN; c++)
        begin
          if (chan_en_i[c])
          begin
            next_stg_local[c][slot] = req_i.wdata & slot_mask(slot); // see R4, R16
          end
        end
      end
    end
    if (req_i.rd)
    begin
      // Reads return the staged value; open bits are stored as zero.
      if (req_i.addr == ADDR_APPLY)
      begin
        next_rdata = {7'h00, apply_bit};
      end
      else if (req_i.addr == ADDR_CLOCK_DIV)
      begin
        next_rdata = stg_clock_div;
      end
      else if (slot != 3'h5)
      begin
        next_rdata = stg_local[rc][slot]; // see R4
        if (slot == 3'h0)
        begin
          next_rdata = stg_local[rc][slot] | stg_power_glob;
        end
      end
      else
      begin
        next_rdata = 8'h00; // see R16
      end
    end
  end

  // Registers only; synchronous active-low reset.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      stg_power_glob <= RST_POWER_MODE;
      stg_clock_div <= RST_CLOCK_DIV;
      act_power_glob <= RST_POWER_MODE;
      act_clock_div <= RST_CLOCK_DIV;
      apply_bit <= 1'b0; // see R1
      rdata <= 8'h00;
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        for (int s = 0; s < 5; s++)
        begin
          stg_local[c][s] <= slot_reset(3'(s)); // see R6, R9, R15
          act_local[c][s] <= slot_reset(3'(s));
        end
      end
    end
    else
    begin
      stg_power_glob <= next_stg_power_glob;
      stg_clock_div <= next_stg_clock_div;
      stg_local <= next_stg_local;
      act_power_glob <= next_act_power_glob;
      act_clock_div <= next_act_clock_div;
      act_local <= next_act_local;
      apply_bit <= next_apply_bit;
      rdata <= next_rdata;
    end
  end

  // ********************************************************************
  // Decoded active settings
  // ********************************************************************
  // Only the active copies reach the converter, which keeps staged writes inert.
  always_comb
  begin
    glob_o.pd_pin_standby = act_power_glob[PD_PIN_FUNC_BIT]; // see R5
    glob_o.clk_div_ratio_m1 = act_clock_div[2:0]; // see R7
    glob_o.clk_div_phase = act_clock_div[5:3]; // see R8
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      chan_o[c].power_mode = act_local[c][0][1:0]; // see R6
      chan_o[c].shuffle_en = act_local[c][1][SHUFFLE_BIT]; // see R9
      chan_o[c].test_sel = act_local[c][2][2:0]; // see R10, R11
      chan_o[c].long_pn_run = act_local[c][2][LONG_PN_RUN_BIT]; // see R12
      chan_o[c].short_pn_run = act_local[c][2][SHORT_PN_RUN_BIT]; // see R12
      chan_o[c].self_test_start = act_local[c][3][SELF_TEST_EN_BIT]; // see R13
      chan_o[c].self_test_run = act_local[c][3][SELF_TEST_RUN_BIT]; // see R14
      chan_o[c].offset_trim = act_local[c][4]; // see R15
    end
  end

  // Read data leaves straight from its flip-flop, so it holds until the next read.
  // The host may therefore sample it late without a strobe of its own.
  assign rdata_o = rdata;

endmodule

// ---- bench/afc_regs_props.sv ----
`timescale 1ns/100ps
module afc_regs_props
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input afc_pkg::afc_req_t req_i,
  input wire logic [afc_pkg::NUM_CHAN-1:0] chan_en_i,
  input wire logic [7:0] rdata_o,
  input afc_pkg::afc_glob_t glob_o,
  input afc_pkg::afc_chan_t [afc_pkg::NUM_CHAN-1:0] chan_o
);
  import afc_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Request decodes; the test-pattern write watches channel B only.
  wire logic ap = req_i.wr && req_i.addr == ADDR_APPLY && req_i.wdata[APPLY_BIT];
  wire logic rd_ff = req_i.rd && req_i.addr == ADDR_APPLY;
  wire logic w08 = req_i.wr && req_i.addr == ADDR_POWER_MODE;
  wire logic w0b = req_i.wr && req_i.addr == ADDR_CLOCK_DIV;
  wire logic w0d = req_i.wr && req_i.addr == ADDR_TEST_PATTERN && chan_en_i[1];
  sequence s_ap_rd1;
    ap ##1 rd_ff;
  endsequence
  sequence s_div_ap;
    w0b ##1 !w0b ##1 ap;
  endsequence
  // The bench writes power mode, then two other registers, then the transfer.
  sequence s_pd_ap;
    w08 ##1 !w08 [*2] ##1 ap;
  endsequence
  stage_hold_a: assert property (!$stable({glob_o, chan_o}) && $past(rst_n_i) |-> $past(ap, 2))
    else $error("Active settings moved without a transfer.");
  apply_seen_a: assert property (s_ap_rd1 |=> rdata_o == 8'h01)
    else $error("Transfer bit not readable after the write.");
  apply_clear_a: assert property (s_ap_rd1 ##1 rd_ff |=> rdata_o == 8'h00)
    else $error("Transfer bit did not clear itself.");
  rdata_hold_a: assert property (!req_i.rd |=> $stable(rdata_o))
    else $error("Read data moved without a read.");
  open_zero_a: assert property (req_i.rd && req_i.addr == ADDR_POWER_MODE |=>
    (rdata_o & ~MASK_POWER_MODE) == 8'h00)
    else $error("Open bit read back nonzero.");
  unmapped_zero_a: assert property (req_i.rd && req_i.addr == 8'h20 |=> rdata_o == 8'h00)
    else $error("Unmapped address read nonzero.");
  div_apply_a: assert property (s_div_ap |-> ##2
    {2'b00, glob_o.clk_div_phase, glob_o.clk_div_ratio_m1} == ($past(req_i.wdata, 4) & MASK_CLOCK_DIV))
    else $error("Divider settings not applied.");
  pd_apply_a: assert property (s_pd_ap |-> ##2
    glob_o.pd_pin_standby == $past(req_i.wdata[PD_PIN_FUNC_BIT], 5))
    else $error("Power-down pin function not applied.");
  test_apply_a: assert property (w0d ##1 ap |-> ##2 ($past(req_i.wdata, 3) & MASK_TEST_PATTERN) ==
    {2'b00, chan_o[1].long_pn_run, chan_o[1].short_pn_run, 1'b0, chan_o[1].test_sel})
    else $error("Test pattern not applied to channel B.");
endmodule

// ---- bench/afc_host.sv ----
`timescale 1ns/100ps
module afc_host
(
  input wire logic clk_sys_i,
  output afc_pkg::afc_req_t req_o,
  output logic [afc_pkg::NUM_CHAN-1:0] chan_en_o
);
  import afc_pkg::*;
  // Holds one request across one rising edge; callers idle it, so writes never repeat by accident.
  task automatic xfer(input logic w, r, input logic [7:0] a, d);
    req_o = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk_sys_i);
  endtask
  // Channel enables are driven straight from the argument; the index register is never written.
  task automatic sel(input logic [3:0] c);
    chan_en_o = c;
  endtask
  initial
  begin
    req_o = '0;
    chan_en_o = 4'h1;
  end
endmodule

// ---- bench/afc_regs_tb.sv ----
`timescale 1ns/100ps
module afc_regs_tb;
  import afc_pkg::*;
  logic clk_sys_i;
  logic rst_n_i;
  afc_req_t req;
  logic [NUM_CHAN-1:0] chan_en;
  logic [7:0] rdata;
  afc_glob_t glob;
  afc_chan_t [NUM_CHAN-1:0] chan;
  int errors;
  int cmp_count;
  logic [7:0] addr_tab [7] = '{8'h20, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h08};
  logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mask_tab [7] = '{8'h00, 8'h3F, 8'h01, 8'h37, 8'h05, 8'hFF, 8'h23};
  afc_host host (.clk_sys_i(clk_sys_i), .req_o(req), .chan_en_o(chan_en));
  afc_regs DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req), .chan_en_i(chan_en),
    .rdata_o(rdata), .glob_o(glob), .chan_o(chan));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Read data is registered, so it is compared one edge after the read.
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    host.xfer(1'b0, 1'b1, a, 8'h00);
    chk({10'h000, rdata}, {10'h000, exp});
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    errors = 0;
    cmp_count = 0;
    rst_n_i = 1'b0;
    repeat (16) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 7; i++) chk_rd(addr_tab[i], rst_tab[i]);
    chk_rd(ADDR_APPLY, 8'h00);
    chk(chan[3], 18'h08000);
    // All ones to every address on channel A alone, then nothing may move before the transfer.
    for (int i = 0; i < 7; i++) host.xfer(1'b1, 1'b0, addr_tab[i], 8'hFF);
    chk({11'h000, glob}, 18'h00000);
    chk(chan[0], 18'h08000);
    host.xfer(1'b1, 1'b0, ADDR_APPLY, 8'h01);
    chk_rd(ADDR_APPLY, 8'h01);
    chk_rd(ADDR_APPLY, 8'h00);
    chk({11'h000, glob}, 18'h0007F);
    chk(chan[0], 18'h3FFFF);
    chk(chan[1], 18'h08000);
    for (int i = 0; i < 7; i++) chk_rd(addr_tab[i], mask_tab[i]);
    // Every divider and pattern code on channel B alone.
    host.sel(4'h2);
    for (int t = 0; t < 8; t++)
    begin
      logic [2:0] c;
      c = t[2:0];
      host.xfer(1'b1, 1'b0, ADDR_POWER_MODE, {2'b00, c[0], 5'h01});
      host.xfer(1'b1, 1'b0, ADDR_CLOCK_DIV, {2'b00, c, ~c});
      host.xfer(1'b1, 1'b0, ADDR_TEST_PATTERN, {2'b00, c[0], ~c[0], 1'b0, c});
      host.xfer(1'b1, 1'b0, ADDR_APPLY, 8'h01);
      host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
      chk({11'h000, glob}, {11'h000, c[0], ~c, c});
      chk({8'h00, chan[1][17:8]}, {8'h00, PWR_DOWN, 1'b1, c, c[0], ~c[0], 2'b00});
      chk({8'h00, chan[0][17:8]}, 18'h003FF);
    end
    // Channels C and D together; a write in the apply cycle waits for the next transfer.
    host.sel(4'hC);
    host.xfer(1'b1, 1'b0, ADDR_SHUFFLE, 8'h00);
    host.xfer(1'b1, 1'b0, ADDR_OFFSET_TRIM, 8'h80);
    host.xfer(1'b1, 1'b0, ADDR_APPLY, 8'h01);
    host.xfer(1'b1, 1'b0, ADDR_OFFSET_TRIM, 8'h7F);
    host.xfer(1'b1, 1'b0, ADDR_APPLY, 8'h00);
    host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
    chk(chan[2], 18'h00080);
    chk(chan[3], 18'h00080);
    chk_rd(ADDR_OFFSET_TRIM, 8'h7F);
    host.xfer(1'b1, 1'b0, ADDR_APPLY, 8'h01);
    host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
    chk(chan[3], 18'h0007F);
    // Several channels selected: the read answers for channel A.
    host.sel(4'h3);
    chk_rd(ADDR_TEST_PATTERN, 8'h37);
    host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
    complete_run();
  end
endmodule
bind afc_regs afc_regs_props P (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req_i),
  .chan_en_i(chan_en_i), .rdata_o(rdata_o), .glob_o(glob_o), .chan_o(chan_o));
